/* common/dpswc_map.svh */
`ifndef DPSWC_MAP_SVH
`define DPSWC_MAP_SVH
`define DPSWC_ADDR_CTRL 4'h0
`define DPSWC_ADDR_STATUS 4'h1
`define DPSWC_ADDR_WAKE 4'h2
`define DPSWC_ADDR_SETTLE 4'h3
`define DPSWC_CTRL_PORT_OPEN 0
`define DPSWC_CTRL_ANSWER 1
`define DPSWC_CTRL_DIAL 2
`define DPSWC_CTRL_OFF_HOOK 3
`define DPSWC_CTRL_SPEAKER 4
`define DPSWC_WAKE_EN 0
`define DPSWC_WAKE_STS 1
`define DPSWC_WAKE_STS_CHG 2
`define DPSWC_SETTLE_RESET 8'h10
`define DPSWC_SETTLE_NS 1600
`define DPSWC_CLK_NS 100
`define DPSWC_SETTLE_CYC \
    ((`DPSWC_SETTLE_NS + `DPSWC_CLK_NS - 1) / `DPSWC_CLK_NS)
`endif

/* common/dpswc_pkg.sv */
package dpswc_pkg;
    // Gray-coded along D3 -> up -> D0 -> D1 -> down; the step down -> D3 flips two bits
    typedef enum logic [2:0] {
        DPSWC_D3 = 3'h0,
        DPSWC_UP_ISO = 3'h1,
        DPSWC_D0 = 3'h3,
        DPSWC_D1 = 3'h2,
        DPSWC_DOWN_ISO = 3'h6,
        DPSWC_WAKE_D0 = 3'h7
    } dpswc_state_type;

    typedef enum logic [1:0] {
        DPSWC_PS_D0 = 2'h0,
        DPSWC_PS_D1 = 2'h1,
        DPSWC_PS_D3 = 2'h3
    } dpswc_pstate_type;
endpackage

/* hw/dpswc_wake_path.sv */
`timescale 1ns/1ps
// Wake path: gates, a ring edge-detect flop and one sticky flop, no processor in the loop
module dpswc_wake_path
(
    input wire logic clk_sys_i, // System clock
    input wire logic reset_i, // Sync reset, active high
    input wire logic ring_indicate_i, // Ring indicate from phone interface
    input wire logic wake_enable_i, // Wake enable bit
    input wire logic sys_sleeping_i, // System is asleep
    input wire logic wake_clear_i, // Software clear of wake status
    output logic wake_request_o, // Wake request upstream
    output logic wake_status_o // Sticky wake status
);
    logic ring_d_r;
    logic wake_status_r;
    logic ring_rise;

    assign ring_rise = ring_indicate_i & ~ring_d_r;
    // Combinational so it needs no powered plane and no clock gating
    assign wake_request_o = ring_indicate_i
        & wake_enable_i;

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            ring_d_r <= 1'b0;
        else
            ring_d_r <= ring_indicate_i;
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            wake_status_r <= 1'b0;
        else if (ring_rise & wake_enable_i & sys_sleeping_i)
            wake_status_r <= 1'b1;
        else if (wake_clear_i)
            wake_status_r <= 1'b0;
    end

    assign wake_status_o = wake_status_r;
endmodule // dpswc_wake_path

/* hw/dpswc_ctrl.sv */
// The address-and-strobe port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "dpswc_map.svh"
// Modem power-state sequencer with plane, isolation and wake control
module dpswc_ctrl
#(
    parameter int SETTLE_W = 8 // Width of settle counter
)
(
    input wire logic clk_sys_i, // System clock
    input wire logic reset_i, // Sync reset, active high
    input wire logic [3:0] reg_addr_i, // Register address
    input wire logic [31:0] reg_wdata_i, // Write data
    input wire logic reg_wr_i, // Write strobe
    input wire logic reg_rd_i, // Read strobe
    output logic [31:0] reg_rdata_o, // Read data, cycle after strobe
    input wire logic ring_indicate_i, // Ring indicate from phone interface
    input wire logic sys_sleeping_i, // System is sleeping
    output logic main_power_plane_o, // Main plane enable
    output logic line_plane_enable_o, // Line plane enable
    output logic main_iso_o, // Isolate main plane part
    output logic line_iso_o, // Isolate line plane part
    output logic modem_low_power_request_o, // Controller low power
    output logic modem_off_request_o, // Controller off
    output logic context_reset_o, // Context discard pulse
    output logic speaker_en_o, // Speaker on
    output logic off_hook_o, // Line off hook
    output logic wake_request_o, // Wake request upstream
    output logic sci_o, // Status change interrupt request
    output logic [1:0] power_state_o // Current device state
);
    // Needs at least 5 bits to hold the reset settle count
    if (SETTLE_W < 5 || SETTLE_W > 16)
    begin : g_bad_settle_w
        $error("SETTLE_W out of range");
    end

    dpswc_pkg::dpswc_state_type state_r, state_nxt;
    logic [4:0] ctrl_r;
    logic wake_en_r;
    logic chg_r;
    logic [SETTLE_W-1:0] settle_r;
    logic [SETTLE_W-1:0] settle_cnt_r;
    logic [31:0] rdata_r;
    logic wake_sts;
    logic wake_clr;
    logic chg_clr;
    logic settled;
    logic port_open;
    logic answer;
    logic dial;
    logic ring_in_answer;
    logic state_change;
    logic ctx_r;

    assign port_open = ctrl_r[`DPSWC_CTRL_PORT_OPEN];
    assign answer = ctrl_r[`DPSWC_CTRL_ANSWER];
    assign dial = ctrl_r[`DPSWC_CTRL_DIAL];
    assign ring_in_answer = ring_indicate_i & answer;
    assign settled = (settle_cnt_r == '0);
    assign wake_clr = reg_wr_i && reg_addr_i == `DPSWC_ADDR_WAKE
        && reg_wdata_i[`DPSWC_WAKE_STS];
    assign chg_clr = reg_wr_i && reg_addr_i == `DPSWC_ADDR_WAKE
        && reg_wdata_i[`DPSWC_WAKE_STS_CHG];

    // Registers; dial clears itself in D0 while answer is clear, so it reads as a request
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            ctrl_r <= 5'h00;
        else if (reg_wr_i && reg_addr_i == `DPSWC_ADDR_CTRL)
            ctrl_r <= reg_wdata_i[4:0];
        else if (state_r == dpswc_pkg::DPSWC_D0 && !answer)
            ctrl_r[`DPSWC_CTRL_DIAL] <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            wake_en_r <= 1'b0;
        else if (reg_wr_i && reg_addr_i == `DPSWC_ADDR_WAKE)
            wake_en_r <= reg_wdata_i[`DPSWC_WAKE_EN];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            settle_r <= SETTLE_W'(`DPSWC_SETTLE_RESET);
        else if (reg_wr_i && reg_addr_i == `DPSWC_ADDR_SETTLE)
            settle_r <= reg_wdata_i[SETTLE_W-1:0];
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            rdata_r <= 32'h0000_0000;
        else if (reg_rd_i)
        begin
            if (reg_addr_i == `DPSWC_ADDR_CTRL)
                rdata_r <= {27'h0, ctrl_r};
            else if (reg_addr_i == `DPSWC_ADDR_STATUS)
                rdata_r <= {26'h0, state_r, 1'b0, power_state_o};
            else if (reg_addr_i == `DPSWC_ADDR_WAKE)
                rdata_r <= {29'h0, chg_r, wake_sts, wake_en_r};
            else if (reg_addr_i == `DPSWC_ADDR_SETTLE)
                rdata_r <= {{(32 - SETTLE_W){1'b0}}, settle_r};
            else
                rdata_r <= 32'h0000_0000;
        end
        else
            rdata_r <= 32'h0000_0000;
    end
    assign reg_rdata_o = rdata_r;

    // Plane settle timer, reloaded on each plane switch
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            settle_cnt_r <= '0;
        else if (state_nxt != state_r)
            settle_cnt_r <= settle_r;
        else if (!settled)
            settle_cnt_r <= settle_cnt_r - 1'b1;
    end

    // Next-state logic
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            dpswc_pkg::DPSWC_D3:
                if (port_open)
                    state_nxt = dpswc_pkg::DPSWC_UP_ISO;
            dpswc_pkg::DPSWC_UP_ISO:
                // Planes on first, release isolation after they settle
                if (settled)
                    state_nxt = dpswc_pkg::DPSWC_D0;
            dpswc_pkg::DPSWC_D0:
                if (!port_open)
                    state_nxt = dpswc_pkg::DPSWC_DOWN_ISO;
                else if (answer && !dial)
                    state_nxt = dpswc_pkg::DPSWC_D1;
            dpswc_pkg::DPSWC_D1:
                if (!port_open)
                    state_nxt = dpswc_pkg::DPSWC_DOWN_ISO;
                else if (dial || ring_in_answer)
                    state_nxt = dpswc_pkg::DPSWC_WAKE_D0;
            dpswc_pkg::DPSWC_WAKE_D0:
                // Line plane returns; isolation held until it settles
                if (settled)
                    state_nxt = dpswc_pkg::DPSWC_D0;
            dpswc_pkg::DPSWC_DOWN_ISO:
                // Isolate first, drop planes after the settle interval
                if (settled)
                    state_nxt = dpswc_pkg::DPSWC_D3;
            default:
                state_nxt = dpswc_pkg::DPSWC_D3;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            state_r <= dpswc_pkg::DPSWC_D3;
        else
            state_r <= state_nxt;
    end

    // Plane, isolation and mode outputs by state
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            main_power_plane_o <= 1'b0;
            line_plane_enable_o <= 1'b0;
            main_iso_o <= 1'b1;
            line_iso_o <= 1'b1;
            modem_low_power_request_o <= 1'b0;
            modem_off_request_o <= 1'b1;
            power_state_o <= dpswc_pkg::DPSWC_PS_D3;
        end
        else
        begin
            case (state_nxt)
                dpswc_pkg::DPSWC_D0:
                begin
                    main_power_plane_o <= 1'b1;
                    line_plane_enable_o <= 1'b1;
                    main_iso_o <= 1'b0;
                    line_iso_o <= 1'b0;
                    modem_low_power_request_o <= 1'b0;
                    modem_off_request_o <= 1'b0;
                    power_state_o <= dpswc_pkg::DPSWC_PS_D0;
                end
                dpswc_pkg::DPSWC_UP_ISO, dpswc_pkg::DPSWC_WAKE_D0:
                begin
                    main_power_plane_o <= 1'b1;
                    line_plane_enable_o <= 1'b1;
                    main_iso_o <= (state_nxt == dpswc_pkg::DPSWC_UP_ISO);
                    line_iso_o <= 1'b1;
                    modem_low_power_request_o <=
                        (state_nxt == dpswc_pkg::DPSWC_WAKE_D0);
                    modem_off_request_o <=
                        (state_nxt == dpswc_pkg::DPSWC_UP_ISO);
                    power_state_o <= power_state_o;
                end
                dpswc_pkg::DPSWC_D1:
                begin
                    main_power_plane_o <= 1'b1;
                    line_plane_enable_o <= 1'b0;
                    main_iso_o <= 1'b0;
                    line_iso_o <= 1'b1;
                    modem_low_power_request_o <= 1'b1;
                    modem_off_request_o <= 1'b0;
                    power_state_o <= dpswc_pkg::DPSWC_PS_D1;
                end
                dpswc_pkg::DPSWC_DOWN_ISO:
                begin
                    main_power_plane_o <= main_power_plane_o;
                    line_plane_enable_o <= line_plane_enable_o;
                    main_iso_o <= 1'b1;
                    line_iso_o <= 1'b1;
                    modem_low_power_request_o <= 1'b0;
                    modem_off_request_o <= 1'b1;
                    power_state_o <= power_state_o;
                end
                default:
                begin
                    main_power_plane_o <= 1'b0;
                    line_plane_enable_o <= 1'b0;
                    main_iso_o <= 1'b1;
                    line_iso_o <= 1'b1;
                    modem_low_power_request_o <= 1'b0;
                    modem_off_request_o <= 1'b1;
                    power_state_o <= dpswc_pkg::DPSWC_PS_D3;
                end
            endcase
        end
    end

    // Speaker and hook only honoured in full-on state
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            speaker_en_o <= 1'b0;
            off_hook_o <= 1'b0;
        end
        else
        begin
            speaker_en_o <= (state_nxt == dpswc_pkg::DPSWC_D0)
                && ctrl_r[`DPSWC_CTRL_SPEAKER];
            off_hook_o <= (state_nxt == dpswc_pkg::DPSWC_D0)
                && ctrl_r[`DPSWC_CTRL_OFF_HOOK];
        end
    end

    // Context is lost on entering D3
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            ctx_r <= 1'b0;
        else
            ctx_r <= (state_nxt == dpswc_pkg::DPSWC_D3)
                && (state_r != dpswc_pkg::DPSWC_D3);
    end
    assign context_reset_o = ctx_r;

    // Sticky power-state change flag drives the interrupt request
    assign state_change = (state_r != state_nxt)
        && (state_nxt == dpswc_pkg::DPSWC_D0
            || state_nxt == dpswc_pkg::DPSWC_D1
            || state_nxt == dpswc_pkg::DPSWC_D3);
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            chg_r <= 1'b0;
        else if (state_change)
            chg_r <= 1'b1;
        else if (chg_clr)
            chg_r <= 1'b0;
    end
    assign sci_o = chg_r | wake_sts;

    dpswc_wake_path u_wake
    (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ring_indicate_i(ring_indicate_i),
        .wake_enable_i(wake_en_r),
        .sys_sleeping_i(sys_sleeping_i),
        .wake_clear_i(wake_clr),
        .wake_request_o(wake_request_o),
        .wake_status_o(wake_sts)
    );
endmodule // dpswc_ctrl

/* dv/dpswc_ctrl_sva.sv */
`timescale 1ns/1ps
`include "dpswc_map.svh"
module dpswc_ctrl_sva
(
    input wire logic clk_sys_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic [3:0] reg_addr_i, // Address
    input wire logic [31:0] reg_wdata_i, // Data
    input wire logic reg_wr_i, // Write
    input wire logic ring_indicate_i, // Ring
    input wire logic main_power_plane_o, // Main plane
    input wire logic line_plane_enable_o, // Line plane
    input wire logic main_iso_o, // Main iso
    input wire logic line_iso_o, // Line iso
    input wire logic modem_off_request_o, // Off
    input wire logic context_reset_o, // Context
    input wire logic speaker_en_o, // Speaker
    input wire logic off_hook_o, // Hook
    input wire logic wake_request_o, // Wake
    input wire logic [1:0] power_state_o // State
);
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (reset_i);
    a_d0_planes: assert property (
        power_state_o == 2'h0 |-> main_power_plane_o && line_plane_enable_o)
        else $error("D0 without both planes");
    a_d1_quiet: assert property (
        power_state_o == 2'h1 |-> !speaker_en_o && !off_hook_o)
        else $error("D1 with speaker or hook active");
    a_d3_safe: assert property (
        power_state_o == 2'h3 |-> modem_off_request_o && main_iso_o
            && line_iso_o && !speaker_en_o && !off_hook_o)
        else $error("D3 outputs not safe");
    a_iso_unpowered: assert property (
        !main_power_plane_o |-> main_iso_o && line_iso_o)
        else $error("Unpowered part not isolated");
    a_wake_cause: assert property (
        wake_request_o |-> ring_indicate_i)
        else $error("Wake request without ring");
    a_ctx_pulse: assert property (
        context_reset_o |-> power_state_o == 2'h3 ##1 !context_reset_o)
        else $error("Context pulse wrong");
    a_up_settle: assert property (
        $rose(main_power_plane_o) |-> main_iso_o [*8] ##[1:40] !main_iso_o)
        else $error("Isolation not held through settle");
    a_answer_d1: assert property (
        reg_wr_i && reg_addr_i == `DPSWC_ADDR_CTRL && reg_wdata_i[2:0] == 3'h3
            && power_state_o == 2'h0 |-> ##[1:3] power_state_o == 2'h1)
        else $error("Answer mode did not reach D1");
endmodule // dpswc_ctrl_sva
bind dpswc_ctrl dpswc_ctrl_sva dpswc_ctrl_sva_i (
    .clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .ring_indicate_i, .main_power_plane_o, .line_plane_enable_o,
    .main_iso_o, .line_iso_o, .modem_off_request_o, .context_reset_o,
    .speaker_en_o, .off_hook_o, .wake_request_o, .power_state_o
);

/* dv/dpswc_core_model.sv */
`timescale 1ns/1ps
// Core chip set and phone line: rings, sleeps, resumes on a wake request
module dpswc_core_model
#(
    parameter int RESUME_DLY = 3 // Resume latency in cycles
)
(
    input wire logic clk_sys_i, // Clock
    input wire logic reset_i, // Reset
    input wire logic ring_cmd_i, // Ring the line
    input wire logic sleep_cmd_i, // Put system to sleep
    input wire logic wake_request_i, // From modem
    output logic ring_indicate_o, // To modem
    output logic sys_sleeping_o, // System asleep
    output logic resumed_o // Woken by modem
);
    logic [7:0] dly_r;
    always_ff @(posedge clk_sys_i)
        ring_indicate_o <= !reset_i && ring_cmd_i;
    // Resume is hardware only: a processor would be unpowered here
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || !sys_sleeping_o)
        begin
            sys_sleeping_o <= !reset_i && sleep_cmd_i;
            resumed_o <= !reset_i && resumed_o && !sleep_cmd_i;
            dly_r <= 8'h00;
        end
        else if (wake_request_i || dly_r != 8'h00)
        begin
            dly_r <= dly_r + 8'h01;
            sys_sleeping_o <= dly_r != 8'(RESUME_DLY);
            resumed_o <= dly_r == 8'(RESUME_DLY);
        end
    end
endmodule // dpswc_core_model

/* dv/test_device_power_state_wake_ctrl.sv */
`timescale 1ns/1ps
`include "dpswc_map.svh"
module test_device_power_state_wake_ctrl;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [3:0] reg_addr_i = 4'h0;
    logic [31:0] reg_wdata_i = 32'h0;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, ring_cmd = 1'b0, sleep_cmd = 1'b0;
    logic [31:0] reg_rdata_o, d;
    logic ring_indicate_i, sys_sleeping_i, resumed, main_power_plane_o;
    logic line_plane_enable_o, main_iso_o, line_iso_o, modem_off_request_o;
    logic modem_low_power_request_o, context_reset_o, speaker_en_o;
    logic off_hook_o, wake_request_o, sci_o;
    logic [1:0] power_state_o;
    int fail_count = 0;
    int samples_checked = 0;
    int ctx_pulses = 0;
    always #50 clk_sys_i = ~clk_sys_i;
    // Counted mid-cycle so the one-cycle pulse is read while it stands
    always @(negedge clk_sys_i)
        if (!reset_i && context_reset_o === 1'b1)
            ctx_pulses++;
    dpswc_ctrl dpswc_ctrl_i (
        .clk_sys_i, .reset_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
        .reg_rd_i, .reg_rdata_o, .ring_indicate_i, .sys_sleeping_i,
        .main_power_plane_o, .line_plane_enable_o, .main_iso_o, .line_iso_o,
        .modem_low_power_request_o, .modem_off_request_o, .context_reset_o,
        .speaker_en_o, .off_hook_o, .wake_request_o, .sci_o, .power_state_o
    );
    dpswc_core_model dpswc_core_model_i (
        .clk_sys_i, .reset_i, .ring_cmd_i(ring_cmd), .sleep_cmd_i(sleep_cmd),
        .wake_request_i(wake_request_o), .ring_indicate_o(ring_indicate_i),
        .sys_sleeping_o(sys_sleeping_i), .resumed_o(resumed)
    );
    task automatic check(input string name, input logic [31:0] seen, exp);
        if (seen !== exp)
        begin
            $display("ERROR %s expected %h seen %h", name, exp, seen);
            fail_count++;
        end
        samples_checked++;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, logic [31:0] v);
        @(posedge clk_sys_i);
        reg_wr_i <= w;
        reg_rd_i <= !w;
        reg_addr_i <= a;
        reg_wdata_i <= v;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task automatic rdc(input logic [3:0] a, logic [31:0] m, e, string n);
        bus(1'b0, a, 32'h0);
        check(n, d & m, e);
    endtask
    // Sleep request is a one-cycle pulse so the model may resume freely
    task automatic line(input logic s, r);
        @(posedge clk_sys_i);
        sleep_cmd <= s;
        ring_cmd <= r;
        @(posedge clk_sys_i);
        sleep_cmd <= 1'b0;
        cyc(2);
    endtask
    task automatic wait_ps(input logic [1:0] e);
        for (int k = 0; k < 60 && power_state_o !== e; k++)
            cyc(1);
        check("power_state", 32'(power_state_o), 32'(e));
    endtask
    function automatic logic [31:0] outs();
        return {24'h0, main_power_plane_o, line_plane_enable_o, main_iso_o,
            line_iso_o, modem_off_request_o, sci_o, power_state_o};
    endfunction
    task automatic results();
        if (fail_count == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial
    begin
        #300000;
        fail_count++;
        results();
    end
    initial
    begin
        repeat (8) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        cyc(1);
        check("reset_outs", outs(), 32'h3B);
        rdc(`DPSWC_ADDR_SETTLE, 32'hFF, `DPSWC_SETTLE_RESET,
            "settle");
        bus(1'b1, 4'hF, 32'hFFFF_FFFF);
        rdc(4'hF, 32'hFFFF_FFFF, 32'h0, "unmapped");
        bus(1'b1, `DPSWC_ADDR_CTRL, 32'h1);
        cyc(2);
        check("up_outs", outs(), 32'hFB);
        wait_ps(2'h0);
        check("d0_outs", outs(), 32'hC4);
        rdc(`DPSWC_ADDR_STATUS, 32'h3F, 32'h18, "status");
        bus(1'b1, `DPSWC_ADDR_WAKE, 32'h4);
        check("sci_clear", sci_o, 1'b0);
        bus(1'b1, `DPSWC_ADDR_CTRL, 32'h19);
        cyc(1);
        check("audio", {speaker_en_o, off_hook_o}, 2'h3);
        bus(1'b1, `DPSWC_ADDR_CTRL, 32'h1B);
        wait_ps(2'h1);
        check("d1_outs", outs(), 32'h95);
        check("d1_low", modem_low_power_request_o, 1'b1);
        bus(1'b1, `DPSWC_ADDR_CTRL, 32'h1F);
        wait_ps(2'h0);
        bus(1'b1, `DPSWC_ADDR_CTRL, 32'h1B);
        wait_ps(2'h1);
        line(1'b0, 1'b1);
        wait_ps(2'h0);
        check("wake_masked", wake_request_o, 1'b0);
        line(1'b0, 1'b0);
        bus(1'b1, `DPSWC_ADDR_CTRL, 32'h0);
        wait_ps(2'h3);
        check("d3_outs", outs(), 32'h3F);
        bus(1'b1, `DPSWC_ADDR_WAKE, 32'h7);
        line(1'b1, 1'b1);
        check("wake_req", {wake_request_o, main_power_plane_o},
            2'h2);
        cyc(8);
        check("resumed", {resumed, sys_sleeping_i}, 2'h2);
        rdc(`DPSWC_ADDR_WAKE, 32'h3, 32'h3, "wake_sts");
        line(1'b0, 1'b0);
        bus(1'b1, `DPSWC_ADDR_WAKE, 32'h3);
        rdc(`DPSWC_ADDR_WAKE, 32'h3, 32'h1, "wake_clr");
        bus(1'b1, `DPSWC_ADDR_WAKE, 32'h0);
        line(1'b1, 1'b1);
        check("no_wake", wake_request_o, 1'b0);
        rdc(`DPSWC_ADDR_WAKE, 32'h3, 32'h0, "no_sts");
        check("ctx_pulses", ctx_pulses, 1);
        results();
    end
endmodule // test_device_power_state_wake_ctrl
